// ---- dv/sflc_ctrl_tb.sv ----
// Self-checking bench of the function latch control block.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("BAD t=%0t got %0h exp %0h", $time, (a), (e)); end end
module sflc_ctrl_tb;
	import sflc_pkg::*;
	localparam int TB_TICK = 2;
	logic clk_sys_i, rst_b_i, chip_enable_i, pump_event_i, clk_en;
	logic link_clk, link_data, strobe;
	sflc_cfg_t cfg;
	logic [2:0] pump_current;
	logic tri_s, cload, ldr, pdn, fl, ab_ld, ref_ld;
	logic [17:0] ab_word;
	logic [19:0] ref_word;
	logic [31:0] seed = 32'h00012222;
	logic [23:0] w, f, ab;
	int fails = 0;
	int checks_done = 0;
	int pulses = 0;
	int ab_pulses = 0;
	int ref_pulses = 0;
	int n;
	sflc_host i_sflc_host (.clk_sys_i(clk_sys_i), .link_clk_o(link_clk),
		.link_data_o(link_data), .strobe_o(strobe));
	sflc_ctrl #(.TICK_BASE(TB_TICK)) i_sflc_ctrl (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.clk_en_i(clk_en), .link_clk_i(link_clk), .link_data_i(link_data),
		.latch_load_strobe_i(strobe), .chip_enable_i(chip_enable_i),
		.pump_event_i(pump_event_i), .cfg_o(cfg), .pump_current_o(pump_current),
		.pump_tristate_o(tri_s), .counters_load_o(cload), .lock_detect_reset_o(ldr),
		.powered_down_o(pdn), .fastlock_active_o(fl), .ab_word_o(ab_word),
		.ref_word_o(ref_word), .ab_load_o(ab_ld), .ref_load_o(ref_ld));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic sflc_cfg_t exp_cfg(logic [23:0] x);
		return {x[23:22], x[20:15], x[14:11], x[8], x[7], x[6:4]};
	endfunction : exp_cfg
	// Function word with power-down, hold and fastlock enable bits cleared.
	// Any prescaler code is legal here, since no RF input is modelled to overrun it.
	function automatic logic [23:0] fw(logic [23:0] x);
		return {x[23:22], 1'b0, x[20:10], 1'b0, x[8:4], 4'h2};
	endfunction : fw
	task automatic load(input logic [23:0] x);
		pulses = 0;
		ab_pulses = 0;
		ref_pulses = 0;
		i_sflc_host.send(x);
		repeat (4) @(posedge clk_sys_i);
	endtask : load
	task automatic complete_run();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk_sys_i) begin
		if (cload === 1'b1) begin
			pulses++;
		end
		if (ab_ld === 1'b1) begin
			ab_pulses++;
		end
		if (ref_ld === 1'b1) begin
			ref_pulses++;
		end
	end
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		rst_b_i = 1'b0;
		chip_enable_i = 1'b1;
		pump_event_i = 1'b0;
		clk_en = 1'b1;
		repeat (20) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		`CHK({pdn, cload}, 2'b00)
		for (n = 0; n < 6; n++) begin
			repeat (24) seed = lfsr(seed);
			f = fw(seed[23:0]);
			load(f);
			`CHK(cfg, exp_cfg(f))
			`CHK(pump_current, f[17:15])
			`CHK(tri_s, f[8])
		end
		w = {seed[23:2], 2'b00};
		load(w);
		`CHK(ref_word, w[21:2])
		`CHK(ref_pulses, 1)
		`CHK(cfg, exp_cfg(f))
		ab = {3'b000, seed[20:2], 2'b01};
		load(ab);
		`CHK(ab_word, ab[19:2])
		`CHK(ab_pulses, 1)
		// The host clears the hold bit again after using it.
		load(f | 24'h000004);
		`CHK({cload, tri_s, pdn}, 3'b110)
		load(f);
		`CHK(cload, 1'b0)
		chip_enable_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		`CHK({pdn, cload, tri_s, ldr}, 4'hF)
		w = f ^ 24'hDC0070;
		load(w);
		`CHK(cfg, exp_cfg(w))
		chip_enable_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		`CHK({pdn, cload}, 2'b00)
		load(w | 24'h000008);
		`CHK({pdn, cload, tri_s}, 3'b111)
		load(w);
		load(w | 24'h200008);
		`CHK(pdn, 1'b0)
		pump_event_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		`CHK(pdn, 1'b1)
		pump_event_i <= 1'b0;
		load(w);
		`CHK(pdn, 1'b0)
		load(w | 24'h000003);
		`CHK(pulses > 0, 1'b1)
		`CHK(cfg, exp_cfg(w))
		load(ab);
		`CHK(pulses > 0, 1'b1)
		load(ab);
		`CHK(pulses, 0)
		load(w | 24'h20000B);
		`CHK(pdn, 1'b1)
		load(w);
		load(ab | 24'h200000);
		`CHK(fl, 1'b0)
		// Mode bit cleared: mode 1 keeps fastlock on with no timeout at all.
		load((w & 24'hFFFBFF) | 24'h000200);
		repeat (100) @(posedge clk_sys_i);
		`CHK({fl, pump_current}, {1'b1, w[20:18]})
		load(ab);
		`CHK({fl, pump_current}, {1'b0, w[17:15]})
		load(w | 24'h007E00);
		load(ab | 24'h200000);
		`CHK(fl, 1'b1)
		for (n = 0; n < 300 && fl === 1'b1; n++) begin
			@(posedge clk_sys_i);
		end
		`CHK({fl, pump_current}, {1'b0, w[17:15]})
		// The loop starts nine cycles after the strobe; sixteen steps of TB_TICK follow.
		`CHK(n + 9 >= 16 * TB_TICK && n + 9 <= 16 * TB_TICK + 8, 1'b1)
		// With the clock enable low the block must not even see chip enable fall.
		clk_en <= 1'b0;
		chip_enable_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		`CHK(pdn, 1'b0)
		clk_en <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		`CHK(pdn, 1'b1)
		chip_enable_i <= 1'b1;
		complete_run();
	end
endmodule : sflc_ctrl_tb

// ---- dv/sflc_host.sv ----
// Host model that writes 24-bit words over the three-wire programming link.
`timescale 1ns/1ps
module sflc_host (
	input wire logic clk_sys_i,
	output logic link_clk_o,
	output logic link_data_o,
	output logic strobe_o
);
	initial begin
		link_clk_o = 1'b0;
		link_data_o = 1'b0;
		strobe_o = 1'b0;
	end
	// Each bit of the link takes 21 system cycles (168 ns): ten with the clock high, eleven low.
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk_sys_i) link_data_o <= w[i];
			repeat (10) @(posedge clk_sys_i);
			link_clk_o <= 1'b1;
			repeat (10) @(posedge clk_sys_i);
			link_clk_o <= 1'b0;
		end
		repeat (5) @(posedge clk_sys_i);
		strobe_o <= 1'b1;
		// The released data line toggles so a stale bit never looks driven.
		link_data_o <= ~w[0];
		repeat (5) @(posedge clk_sys_i);
		strobe_o <= 1'b0;
	endtask : send
endmodule : sflc_host

// ---- logic/sflc_ctrl.sv ----
// Function and initialization latch control of the synthesizer serial programming port.
`timescale 1ns/1ps
`include "sflc_defs.svh"
module sflc_ctrl #(
	parameter int TICK_BASE = `SFLC_TICK_BASE
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic link_clk_i,
	input wire logic link_data_i,
	input wire logic latch_load_strobe_i,
	input wire logic chip_enable_i,
	input wire logic pump_event_i,
	output sflc_pkg::sflc_cfg_t cfg_o,
	output logic [2:0] pump_current_o,
	output logic pump_tristate_o,
	output logic counters_load_o,
	output logic lock_detect_reset_o,
	output logic powered_down_o,
	output logic fastlock_active_o,
	output logic [17:0] ab_word_o,
	output logic [19:0] ref_word_o,
	output logic ab_load_o,
	output logic ref_load_o
);
	import sflc_pkg::*;

	// The tick counter is 16 bits wide, so a longer tick cannot be counted.
	if (TICK_BASE < 1 || TICK_BASE > 65536) begin : g_bad_tick
		$error("TICK_BASE must lie between 1 and 65536");
	end

	logic clk_rise;
	logic data_q;
	logic le_rise;
	logic ce_q;
	logic cpe_rise;
	logic [23:0] shift_r;
	logic [23:0] func_r;
	logic gain_r;
	logic hold_r;
	logic init_armed_r;
	logic init_pulse_r;
	sflc_pd_t pd_r;
	sflc_pd_t pd_nxt;
	logic [15:0] tick_r;
	logic [3:0] tmo_r;
	logic fl_mode2;
	logic fl_on;
	logic prog_async;
	logic prog_sync;
	logic [1:0] sel;

	sflc_sync u_clk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(clk_en_i),
		.d_i(link_clk_i), .q_o(), .rise_o(clk_rise));
	sflc_sync u_dat (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(clk_en_i),
		.d_i(link_data_i), .q_o(data_q), .rise_o());
	sflc_sync u_le (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(clk_en_i),
		.d_i(latch_load_strobe_i), .q_o(), .rise_o(le_rise));
	sflc_sync u_ce (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(clk_en_i),
		.d_i(chip_enable_i), .q_o(ce_q), .rise_o());
	sflc_sync u_cpe (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(clk_en_i),
		.d_i(pump_event_i), .q_o(), .rise_o(cpe_rise));

	// Data is synchronised alongside the clock, so both arrive with equal latency.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_r <= 24'h000000;
		end else if (clk_en_i && clk_rise) begin
			shift_r <= {shift_r[22:0], data_q};
		end
	end

	assign sel = shift_r[1:0];

	// Function fields; an initialization word writes the same fields.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			func_r <= `SFLC_FUNC_RST;
		end else if (clk_en_i && le_rise &&
			(sel == `SFLC_SEL_FUNC || sel == `SFLC_SEL_INIT)) begin
			func_r <= shift_r;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ab_word_o <= 18'h00000;
			ref_word_o <= 20'h00000;
			ab_load_o <= 1'b0;
			ref_load_o <= 1'b0;
		end else if (clk_en_i) begin
			ab_load_o <= le_rise && sel == `SFLC_SEL_AB;
			ref_load_o <= le_rise && sel == `SFLC_SEL_REF;
			if (le_rise && sel == `SFLC_SEL_AB) begin
				ab_word_o <= shift_r[19:2];
			end
			if (le_rise && sel == `SFLC_SEL_REF) begin
				ref_word_o <= shift_r[21:2];
			end
		end
	end

	// Internal reset pulse: on initialization and on the first AB load after it.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			init_armed_r <= 1'b0;
			init_pulse_r <= 1'b0;
		end else if (clk_en_i) begin
			init_pulse_r <= 1'b0;
			if (le_rise && sel == `SFLC_SEL_INIT) begin
				init_armed_r <= 1'b1;
				init_pulse_r <= 1'b1;
			end else if (le_rise && sel == `SFLC_SEL_AB && init_armed_r) begin
				init_armed_r <= 1'b0;
				init_pulse_r <= 1'b1;
			end
		end
	end

	assign hold_r = func_r[`SFLC_B_HOLD];
	assign prog_async = func_r[`SFLC_B_PD1] & ~func_r[`SFLC_B_PD2];
	assign prog_sync = func_r[`SFLC_B_PD1] & func_r[`SFLC_B_PD2];

	// Power-down state: chip enable dominates, asynchronous mode acts at once,
	// synchronous mode waits for a pump event or the initialization pulse.
	always_comb begin
		pd_nxt = pd_r;
		if (!ce_q || prog_async) begin
			pd_nxt = SFLC_PD;
		end else if (prog_sync) begin
			// The initialization pulse arrives with the word itself, so it must act
			// from the run state too; otherwise the pulse is gone before the wait.
			if (cpe_rise || init_pulse_r) begin
				pd_nxt = SFLC_PD;
			end else if (pd_r == SFLC_RUN) begin
				pd_nxt = SFLC_PD_WAIT;
			end
		end else begin
			pd_nxt = SFLC_RUN;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pd_r <= SFLC_RUN;
		end else if (clk_en_i) begin
			pd_r <= pd_nxt;
		end
	end

	assign fl_mode2 = func_r[`SFLC_B_FLEN] & func_r[`SFLC_B_FLMODE];

	// Gain bit: written by the AB latch, cleared by the mode 2 timeout.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gain_r <= 1'b0;
		end else if (clk_en_i) begin
			if (le_rise && sel == `SFLC_SEL_AB) begin
				gain_r <= shift_r[`SFLC_B_GAIN];
			end else if (fl_mode2 && gain_r && tmo_r == 4'h0 &&
				tick_r == 16'h0000) begin
				gain_r <= 1'b0;
			end
		end
	end

	// Timeout counts (field+1)*TICK_BASE cycles; held in load state otherwise.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_r <= 16'h0000;
			tmo_r <= 4'h0;
		end else if (clk_en_i) begin
			if (!fl_mode2 || !gain_r || pd_r == SFLC_PD || init_pulse_r ||
				(le_rise && sel == `SFLC_SEL_AB)) begin
				tick_r <= 16'(TICK_BASE - 1);
				tmo_r <= func_r[`SFLC_B_TC_HI:`SFLC_B_TC_LO];
			end else if (tick_r != 16'h0000) begin
				tick_r <= tick_r - 16'h0001;
			end else if (tmo_r != 4'h0) begin
				tick_r <= 16'(TICK_BASE - 1);
				tmo_r <= tmo_r - 4'h1;
			end
		end
	end

	assign fl_on = func_r[`SFLC_B_FLEN] & gain_r;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_o <= '0;
			pump_current_o <= 3'h0;
			pump_tristate_o <= 1'b1;
			counters_load_o <= 1'b1;
			lock_detect_reset_o <= 1'b1;
			powered_down_o <= 1'b1;
			fastlock_active_o <= 1'b0;
		end else if (clk_en_i) begin
			cfg_o.prescaler <= func_r[`SFLC_B_PRE_HI:`SFLC_B_PRE_LO];
			cfg_o.cp_secondary <= func_r[`SFLC_B_CP2_HI:`SFLC_B_CP2_LO];
			cfg_o.cp_primary <= func_r[`SFLC_B_CP1_HI:`SFLC_B_CP1_LO];
			cfg_o.timeout <= func_r[`SFLC_B_TC_HI:`SFLC_B_TC_LO];
			cfg_o.tristate <= func_r[`SFLC_B_TRI];
			cfg_o.polarity <= func_r[`SFLC_B_POL];
			cfg_o.testout_sel <= func_r[`SFLC_B_MUX_HI:`SFLC_B_MUX_LO];
			pump_current_o <= fl_on ? func_r[`SFLC_B_CP2_HI:`SFLC_B_CP2_LO]
				: func_r[`SFLC_B_CP1_HI:`SFLC_B_CP1_LO];
			pump_tristate_o <= func_r[`SFLC_B_TRI] | pd_nxt == SFLC_PD |
				hold_r | init_pulse_r;
			// Hold and release act on both counters in the same cycle.
			counters_load_o <= pd_nxt == SFLC_PD | hold_r | init_pulse_r;
			lock_detect_reset_o <= pd_nxt == SFLC_PD;
			powered_down_o <= pd_nxt == SFLC_PD;
			fastlock_active_o <= fl_on;
		end
	end

	// Power-down, counter hold and release.
	a_ce_pd: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !ce_q |=> powered_down_o && counters_load_o)
		else $error("chip enable low did not power down");
	a_async_pd: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && prog_async |=> powered_down_o && pump_tristate_o)
		else $error("async power-down missed");
	a_sync_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		pd_r == SFLC_PD_WAIT && ce_q && prog_sync && !cpe_rise && !init_pulse_r
		|=> !powered_down_o)
		else $error("sync power-down did not wait");
	a_init_sync_pd: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && ce_q && prog_sync && init_pulse_r |=> powered_down_o)
		else $error("initialization pulse did not trigger power-down");
	a_pd_effects: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && pd_nxt == SFLC_PD |=> lock_detect_reset_o && counters_load_o && pump_tristate_o)
		else $error("power-down side effects missing");
	a_pd_tmo: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && pd_r == SFLC_PD |=> tmo_r == $past(func_r[14:11]))
		else $error("timeout counter not at load state in power-down");
	a_run_release: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && ce_q && !func_r[3] && !hold_r && !init_pulse_r |=> !counters_load_o)
		else $error("counters not released");
	a_hold_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && hold_r |=> counters_load_o)
		else $error("hold bit did not hold counters");
	a_hold_tri: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && hold_r |=> pump_tristate_o)
		else $error("hold bit did not three-state the pump");

	// Serial shifting and latch routing.
	a_shift_in: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && clk_rise |=> shift_r[0] == $past(data_q))
		else $error("serial bit not shifted in");
	a_pd_shift: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && clk_rise && powered_down_o |=> shift_r[23:1] == $past(shift_r[22:0]))
		else $error("shift register stalled in power-down");
	a_func_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h2 |=> func_r == $past(shift_r))
		else $error("function word not latched");
	a_init_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h3 |=> func_r == $past(shift_r))
		else $error("initialization word not latched");
	a_ab_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h1 |=> ab_load_o && ab_word_o == $past(shift_r[19:2]))
		else $error("AB word not latched");
	a_ref_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h0 |=> ref_load_o && ref_word_o == $past(shift_r[21:2]))
		else $error("reference word not latched");
	a_init_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h3 |=> init_pulse_r ##1 counters_load_o)
		else $error("initialization pulse missing");
	a_init_armed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h1 && init_armed_r |=> init_pulse_r && !init_armed_r)
		else $error("first AB load after initialization gave no pulse");
	a_ab_once: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h1 && !init_armed_r |=> !init_pulse_r)
		else $error("reset pulse on later AB load");

	// Pump currents and configuration copies.
	a_pump_cur: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !fl_on |=> pump_current_o == $past(func_r[17:15]))
		else $error("primary current wrong");
	a_fast_cur: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && fl_on |=> pump_current_o == $past(func_r[20:18]))
		else $error("secondary current wrong");
	a_cur_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i |=> cfg_o.cp_secondary == $past(func_r[20:18]) &&
		cfg_o.cp_primary == $past(func_r[17:15]))
		else $error("current settings not copied");
	a_cfg_mux: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i |=> cfg_o.testout_sel == $past(func_r[6:4]))
		else $error("test output select not copied");
	a_pol_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i |=> cfg_o.polarity == $past(func_r[7]))
		else $error("polarity not copied");
	a_tri_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && func_r[8] |=> pump_tristate_o)
		else $error("pump not three-stated");

	// Fastlock modes and the timeout counter.
	a_fl_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !func_r[9] |=> !fastlock_active_o)
		else $error("fastlock active while disabled");
	a_fl_on: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && func_r[9] && gain_r |=> fastlock_active_o)
		else $error("fastlock not active with gain bit set");
	a_mode1_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !fl_mode2 && gain_r && !le_rise |=> gain_r)
		else $error("mode 1 gain cleared without write");
	a_mode1_enter: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && le_rise && sel == 2'h1 |=> gain_r == $past(shift_r[21]))
		else $error("gain bit not taken from AB word");
	a_mode2_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && fl_mode2 && gain_r && tmo_r == 4'h0 && tick_r == 16'h0000 &&
		!(le_rise && sel == 2'h1) |=> !gain_r)
		else $error("gain bit not cleared at timeout");
	a_tmo_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !fl_mode2 |=> tmo_r == $past(func_r[14:11]))
		else $error("timeout counter ran outside mode 2");
	a_tick_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_en_i && !fl_mode2 |=> tick_r == 16'(TICK_BASE - 1))
		else $error("tick counter ran outside mode 2");
endmodule : sflc_ctrl

// ---- logic/sflc_sync.sv ----
// Two-flop synchroniser with edge detection on the second stage output.
`timescale 1ns/1ps
module sflc_sync (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic d_i,
	output logic q_o,
	output logic rise_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else if (ce_i) begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign q_o = s2_r;
	assign rise_o = ce_i & s2_r & ~s3_r;
endmodule : sflc_sync

// ---- pkg/sflc_defs.svh ----
// Bit positions, select codes, reset values and timing counts of the serial programming latches.
`ifndef SFLC_DEFS_SVH
`define SFLC_DEFS_SVH
`define SFLC_WORD_W 24
`define SFLC_SEL_REF 2'h0
`define SFLC_SEL_AB 2'h1
`define SFLC_SEL_FUNC 2'h2
`define SFLC_SEL_INIT 2'h3
`define SFLC_B_HOLD 2
`define SFLC_B_PD1 3
`define SFLC_B_MUX_LO 4
`define SFLC_B_MUX_HI 6
`define SFLC_B_POL 7
`define SFLC_B_TRI 8
`define SFLC_B_FLEN 9
`define SFLC_B_FLMODE 10
`define SFLC_B_TC_LO 11
`define SFLC_B_TC_HI 14
`define SFLC_B_CP1_LO 15
`define SFLC_B_CP1_HI 17
`define SFLC_B_CP2_LO 18
`define SFLC_B_CP2_HI 20
`define SFLC_B_PD2 21
`define SFLC_B_PRE_LO 22
`define SFLC_B_PRE_HI 23
`define SFLC_B_GAIN 21
`define SFLC_FUNC_RST 24'h000000
`define SFLC_TICK_BASE 4
`endif

// ---- pkg/sflc_pkg.sv ----
// Types shared by the synthesizer function latch control block.
package sflc_pkg;
	typedef struct packed {
		logic [1:0] prescaler;
		logic [2:0] cp_secondary;
		logic [2:0] cp_primary;
		logic [3:0] timeout;
		logic tristate;
		logic polarity;
		logic [2:0] testout_sel;
	} sflc_cfg_t;
	typedef enum logic [1:0] {
		SFLC_RUN,
		SFLC_PD_WAIT,
		SFLC_PD
	} sflc_pd_t;
endpackage : sflc_pkg
